// ===== core/zone_supervision_and_tuning.sv
// Purpose: Supervision, manual change, sensor decode and tuning choice of one zone
// Assumes: Measurements arrive on the system clock; external pins pass 3 flops
// Notes: PID, tuning arithmetic and serial protocol live elsewhere
`timescale 1ns/1ps
module zone_supervision_and_tuning #(
  parameter int unsigned TICK_CYCLES = zone_pkg::SECOND_CYCLES,
  parameter int TIME_W = 10
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [1:0] mode_i,
  input wire logic soft_change_i,
  input wire logic short_sense_en_i,
  input wire logic act_sense_en_i,
  input wire logic standby_pin_i,
  input wire logic global_standby_telegram_i,
  input wire logic reset_cmd_i,
  input wire logic power_up_i,
  input wire logic signed [7:0] mean_rate_i,
  input wire logic signed [7:0] ctrl_rate_i,
  input wire logic signed [7:0] min_rate_i,
  input wire logic rate_wr_i,
  input wire logic signed [7:0] rate_wdata_i,
  input wire logic preset_wr_i,
  input wire logic signed [7:0] preset_wdata_i,
  input wire logic [2:0] sensor_type_i,
  input wire logic [15:0] loop_current_ua_i,
  input wire logic signed [15:0] raw_temp_i,
  input wire logic signed [15:0] setpoint_i,
  input wire logic setpoint_wr_i,
  input wire logic signed [15:0] dev_limit_i,
  input wire logic [TIME_W-1:0] diag_time_i,
  input wire logic cooling_active_i,
  input wire logic tune_start_i,
  input wire logic vmax_found_i,
  output logic signed [7:0] out_rate_o,
  output logic rate_ack_o,
  output logic rate_nak_o,
  output logic preset_nak_o,
  output logic signed [15:0] host_temp_o,
  output logic tenth_scale_o,
  output logic [2:0] linear_sel_o,
  output logic broken_sensor_o,
  output logic heat_off_o,
  output logic lo_alarm_contact_o,
  output logic hi_alarm_contact_o,
  output logic [15:0] status_o,
  output logic deviation_alarm_o,
  output logic drop_o,
  output logic tune_start_trial_o,
  output logic tune_osc_trial_o,
  output logic tune_abort_o
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [2:0] pin_sync_reg;
  logic [1:0] mode_prev_reg;
  logic standby_pin_reg, sec_tick, dev_seen_reg, short_cond, act_cond;
  logic short_alarm_reg, act_alarm_reg;
  logic signed [7:0] manual_rate_reg, preset_reg;
  logic signed [15:0] temp, dev, rise_lim, rate_lim;
  logic signed [15:0] short_ref_reg, act_ref_reg, tune_prev_reg, tune_sp_reg;
  logic [TIME_W-1:0] short_timer_reg, act_timer_reg;
  zone_pkg::tune_state_t tune_state_reg;
  // Absolute difference used by deviation and tolerance checks
  function automatic logic signed [15:0] abs16(input logic signed [15:0] v);
    abs16 = v[15] ? -v : v;
  endfunction
  // Value times 100 compared against setpoint times 80
  function automatic logic below_pct(input logic signed [15:0] v,
                                     input logic signed [15:0] sp);
    logic signed [31:0] lhs;
    logic signed [31:0] rhs;
    lhs = 32'(v) * zone_pkg::PCT_FULL;
    rhs = 32'(sp) * zone_pkg::TUNE_PCT;
    below_pct = lhs < rhs;
  endfunction
  sec_tick #(.PERIOD(TICK_CYCLES)) u_tick (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .tick_o(sec_tick)
  );
  // ----------------------------------------
  // Standby pin synchroniser
  // ----------------------------------------
  // Change counts only once stages two and three agree
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_sync_reg <= 3'h0;
      standby_pin_reg <= 1'b0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[1:0], standby_pin_i};
      if (pin_sync_reg[2] == pin_sync_reg[1]) begin
        standby_pin_reg <= pin_sync_reg[2];
      end
    end
  end

  // Drop: global sources or own mode code
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      drop_o <= 1'b0;
    end else begin
      drop_o <= standby_pin_reg | global_standby_telegram_i |
                (mode_i == zone_pkg::MODE_DROP);
    end
  end
  // ----------------------------------------
  // Sensor decode and scaling
  // ----------------------------------------
  // Tenth RTD clipped at 200.0; host sees the same tenths scale
  always_comb begin
    temp = raw_temp_i;
    if (sensor_type_i == zone_pkg::SENS_RTD_TENTH && raw_temp_i > zone_pkg::TENTH_RANGE_MAX) begin
      temp = zone_pkg::TENTH_RANGE_MAX;
    end
  end
  assign rise_lim = (sensor_type_i == zone_pkg::SENS_RTD_TENTH) ?
                    16'(zone_pkg::RISE_TENTH) : 16'(zone_pkg::RISE_DEG);
  assign rate_lim = (sensor_type_i == zone_pkg::SENS_RTD_TENTH) ?
                    16'(zone_pkg::RATE_LIM_TENTH) : 16'(zone_pkg::RATE_LIM_DEG);
  assign dev = abs16(temp - setpoint_i);
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      linear_sel_o <= zone_pkg::SENS_COMP;
      tenth_scale_o <= 1'b0;
      host_temp_o <= 16'sh0000;
      broken_sensor_o <= 1'b0;
    end else begin
      linear_sel_o <= sensor_type_i;
      tenth_scale_o <= (sensor_type_i == zone_pkg::SENS_RTD_TENTH);
      host_temp_o <= temp;
      broken_sensor_o <= (sensor_type_i == zone_pkg::SENS_LOOP) &&
                         (loop_current_ua_i < zone_pkg::LOOP_BREAK_UA);
    end
  end
  // ----------------------------------------
  // Output rate, preset and manual change
  // ----------------------------------------
  // Preset only stored here; it acts solely at the change from auto to manual
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      preset_reg <= zone_pkg::PRESET_RST;
      preset_nak_o <= 1'b0;
    end else begin
      preset_nak_o <= 1'b0;
      if (preset_wr_i) begin
        if (preset_wdata_i > zone_pkg::RATE_FULL || preset_wdata_i < -zone_pkg::RATE_FULL) begin
          preset_nak_o <= 1'b1;
        end else begin
          preset_reg <= preset_wdata_i;
        end
      end
    end
  end
  // Manual rate chosen on entry from auto, then host writes only in manual
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_prev_reg <= zone_pkg::MODE_AUTO;
      manual_rate_reg <= zone_pkg::RATE_ZERO;
      rate_ack_o <= 1'b0;
      rate_nak_o <= 1'b0;
    end else begin
      mode_prev_reg <= mode_i;
      rate_ack_o <= 1'b0;
      rate_nak_o <= 1'b0;
      if (mode_i == zone_pkg::MODE_MANUAL && mode_prev_reg == zone_pkg::MODE_AUTO) begin
        manual_rate_reg <= soft_change_i ? mean_rate_i : preset_reg;
      end else if (rate_wr_i) begin
        if (mode_i == zone_pkg::MODE_MANUAL) begin
          manual_rate_reg <= rate_wdata_i;
          rate_ack_o <= 1'b1;
        end else begin
          rate_nak_o <= 1'b1;
        end
      end
    end
  end

  // Final output: short alarm and off mode force zero, start trial forces full
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_rate_o <= zone_pkg::RATE_ZERO;
      heat_off_o <= 1'b0;
    end else begin
      heat_off_o <= short_alarm_reg;
      if (short_alarm_reg || mode_i == zone_pkg::MODE_OFF) begin
        out_rate_o <= zone_pkg::RATE_ZERO;
      end else if (tune_state_reg == zone_pkg::TUNE_START) begin
        out_rate_o <= zone_pkg::RATE_FULL;
      end else if (mode_i == zone_pkg::MODE_MANUAL) begin
        out_rate_o <= manual_rate_reg;
      end else begin
        out_rate_o <= ctrl_rate_i;
      end
    end
  end
  // ----------------------------------------
  // Plausibility supervision
  // ----------------------------------------
  // Deviation memory arms sensor-short so full output alone never trips it
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      deviation_alarm_o <= 1'b0;
      dev_seen_reg <= 1'b0;
    end else begin
      deviation_alarm_o <= (mode_i != zone_pkg::MODE_OFF) && (dev > dev_limit_i);
      if (deviation_alarm_o) begin
        dev_seen_reg <= 1'b1;
      end else if (setpoint_wr_i || reset_cmd_i || power_up_i) begin
        dev_seen_reg <= 1'b0;
      end
    end
  end

  assign short_cond = short_sense_en_i && (diag_time_i != '0) &&
                      (setpoint_i != 16'sh0000) &&
                      (mode_i == zone_pkg::MODE_AUTO || mode_i == zone_pkg::MODE_DROP) &&
                      (temp < setpoint_i - dev_limit_i) &&
                      (ctrl_rate_i >= zone_pkg::RATE_NEAR_FULL) && dev_seen_reg;
  assign act_cond = act_sense_en_i && (diag_time_i != '0) && (setpoint_i != 16'sh0000) &&
                    (mode_i != zone_pkg::MODE_MANUAL) && (temp > setpoint_i + dev_limit_i) &&
                    (ctrl_rate_i <= min_rate_i);

  // Timers restart with a fresh reference whenever a condition drops
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      short_timer_reg <= '0;
      short_ref_reg <= 16'sh0000;
    end else if (!short_cond || short_timer_reg >= diag_time_i) begin
      short_timer_reg <= '0;
      short_ref_reg <= temp;
    end else if (sec_tick) begin
      short_timer_reg <= short_timer_reg + 1'b1;
    end
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      act_timer_reg <= '0;
      act_ref_reg <= 16'sh0000;
    end else if (!act_cond || act_timer_reg >= diag_time_i) begin
      act_timer_reg <= '0;
      act_ref_reg <= temp;
    end else if (sec_tick) begin
      act_timer_reg <= act_timer_reg + 1'b1;
    end
  end
  // Sensor short latches; set wins over a same-cycle clear
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      short_alarm_reg <= 1'b0;
    end else if (short_cond && short_timer_reg >= diag_time_i &&
                 (temp - short_ref_reg) < rise_lim) begin
      short_alarm_reg <= 1'b1;
    end else if (setpoint_wr_i || reset_cmd_i || power_up_i) begin
      short_alarm_reg <= 1'b0;
    end
  end
  // Actuator short also clears by itself back inside tolerance
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      act_alarm_reg <= 1'b0;
    end else if (act_cond && act_timer_reg >= diag_time_i &&
                 (temp - act_ref_reg) >= rise_lim) begin
      act_alarm_reg <= 1'b1;
    end else if (setpoint_wr_i || dev <= dev_limit_i) begin
      act_alarm_reg <= 1'b0;
    end
  end
  // Contacts and status word
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lo_alarm_contact_o <= 1'b0;
      hi_alarm_contact_o <= 1'b0;
      status_o <= zone_pkg::STATUS_RST;
    end else begin
      lo_alarm_contact_o <= short_alarm_reg;
      hi_alarm_contact_o <= act_alarm_reg;
      status_o <= zone_pkg::STATUS_RST;
      status_o[zone_pkg::STATUS_SHORT_BIT] <= short_alarm_reg;
    end
  end
  // ----------------------------------------
  // Self-tuning trial selection
  // ----------------------------------------
  // Aborts leave parameters untouched; only the flag tells the math side
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tune_state_reg <= zone_pkg::TUNE_IDLE;
      tune_prev_reg <= 16'sh0000;
      tune_sp_reg <= 16'sh0000;
      tune_abort_o <= 1'b0;
      tune_start_trial_o <= 1'b0;
      tune_osc_trial_o <= 1'b0;
    end else begin
      tune_abort_o <= 1'b0;
      case (tune_state_reg)
        zone_pkg::TUNE_IDLE: begin
          tune_prev_reg <= temp;
          tune_sp_reg <= setpoint_i;
          if (tune_start_i) begin
            if (below_pct(temp, setpoint_i)) begin
              tune_state_reg <= zone_pkg::TUNE_START;
              tune_start_trial_o <= 1'b1;
            end else if (!cooling_active_i) begin
              tune_state_reg <= zone_pkg::TUNE_OSC;
              tune_osc_trial_o <= 1'b1;
            end else begin
              tune_abort_o <= 1'b1;
            end
          end
        end
        zone_pkg::TUNE_START: begin
          if (sec_tick) begin
            tune_prev_reg <= temp;
          end
          if ((!below_pct(temp, tune_sp_reg) && !vmax_found_i) ||
              (sec_tick && temp < tune_prev_reg) ||
              (sec_tick && (temp - tune_prev_reg) > rate_lim) ||
              setpoint_i != tune_sp_reg) begin
            tune_abort_o <= 1'b1;
            tune_state_reg <= zone_pkg::TUNE_DONE;
          end else if (vmax_found_i) begin
            tune_state_reg <= zone_pkg::TUNE_DONE;
          end
        end
        zone_pkg::TUNE_OSC: begin
          if (setpoint_i != tune_sp_reg || vmax_found_i) begin
            tune_abort_o <= setpoint_i != tune_sp_reg;
            tune_state_reg <= zone_pkg::TUNE_DONE;
          end
        end
        zone_pkg::TUNE_DONE: begin
          tune_start_trial_o <= 1'b0;
          tune_osc_trial_o <= 1'b0;
          tune_state_reg <= zone_pkg::TUNE_IDLE;
        end
        default: tune_state_reg <= zone_pkg::TUNE_IDLE;
      endcase
    end
  end
endmodule // zone_supervision_and_tuning

// ===== core/zone_pkg.sv
// Purpose: Shared constants and types for the zone supervision block
// Assumes: 40 MHz system clock, temperatures as signed integers (degrees or tenths)
// Notes: Output rates are signed percent, -100 to +100
package zone_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned SECOND_MS = 1000;
  localparam int unsigned SECOND_CYCLES = CLK_HZ / 1000 * SECOND_MS / 1000;
  // ----------------------------------------
  // Mode and sensor encodings
  // ----------------------------------------
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_MANUAL = 2'h1;
  localparam logic [1:0] MODE_AUTO = 2'h2;
  localparam logic [1:0] MODE_DROP = 2'h3;
  localparam logic [2:0] SENS_COMP = 3'h0;
  localparam logic [2:0] SENS_RTD = 3'h1;
  localparam logic [2:0] SENS_TC_A = 3'h2;
  localparam logic [2:0] SENS_TC_B = 3'h3;
  localparam logic [2:0] SENS_VOLT = 3'h4;
  localparam logic [2:0] SENS_UNUSED = 3'h5;
  localparam logic [2:0] SENS_LOOP = 3'h6;
  localparam logic [2:0] SENS_RTD_TENTH = 3'h7;
  // ----------------------------------------
  // Limits and reset values
  // ----------------------------------------
  localparam logic signed [7:0] RATE_FULL = 8'sh64;
  localparam logic signed [7:0] RATE_NEAR_FULL = 8'sh63;
  localparam logic signed [7:0] RATE_ZERO = 8'sh00;
  localparam logic signed [7:0] PRESET_RST = 8'sh00;
  localparam int RISE_DEG = 5;
  localparam int RISE_TENTH = 50;
  localparam int RATE_LIM_DEG = 1;
  localparam int RATE_LIM_TENTH = 10;
  localparam logic [15:0] LOOP_BREAK_UA = 16'h07D0;
  localparam logic signed [15:0] TENTH_RANGE_MAX = 16'sh07D0;
  localparam int TUNE_PCT = 80;
  localparam int PCT_FULL = 100;
  localparam int STATUS_SHORT_BIT = 4;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  typedef enum logic [1:0] {TUNE_IDLE, TUNE_START, TUNE_OSC, TUNE_DONE} tune_state_t;
endpackage

// ===== core/sec_tick.sv
// Purpose: Tick generator; the default period SECOND_CYCLES is 40000 cycles, 1 ms at 40 MHz
// Assumes: Free-running system clock
// Notes: Tick is a one-cycle pulse
`timescale 1ns/1ps
module sec_tick #(
  parameter int unsigned PERIOD = zone_pkg::SECOND_CYCLES
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  output logic tick_o
);
  logic [31:0] cnt_reg;

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  // Wraps at period; tick marks the wrap
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= 32'h0000_0000;
      tick_o <= 1'b0;
    end else if (cnt_reg >= PERIOD - 1) begin
      cnt_reg <= 32'h0000_0000;
      tick_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
      tick_o <= 1'b0;
    end
  end
endmodule // sec_tick

// ===== sim/zone_plant.sv
// Purpose: Behavioural sensor and heater of one zone
// Assumes: One degree per clock while heating
// Notes: Fault 1 freezes the reading, fault 2 heats with heater off
`timescale 1ns/1ps
module zone_plant (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic load_i,
  input wire logic signed [15:0] load_val_i,
  input wire logic heat_i,
  input wire logic [1:0] fault_i,
  output logic signed [15:0] temp_o
);
  // ----------------------------------------
  // Temperature
  // ----------------------------------------
  // A shorted sensor never shows the heat, so a frozen reading stands for it
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      temp_o <= 16'sh0014;
    end else if (load_i) begin
      temp_o <= load_val_i;
    end else if (fault_i == 2'h2 || (fault_i == 2'h0 && heat_i)) begin
      temp_o <= temp_o + 16'sh0001; // Stuck actuator heats anyway
    end
  end
endmodule // zone_plant

// ===== sim/zone_supervision_and_tuning_chk.sv
// Purpose: Port-level checker of the zone supervision block
// Assumes: Single clock domain
// Notes: Bound to every instance of the block
`timescale 1ns/1ps
module zone_supervision_and_tuning_chk (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [1:0] mode_i,
  input wire logic soft_change_i,
  input wire logic short_sense_en_i,
  input wire logic global_standby_telegram_i,
  input wire logic reset_cmd_i,
  input wire logic power_up_i,
  input wire logic setpoint_wr_i,
  input wire logic signed [7:0] mean_rate_i,
  input wire logic rate_wr_i,
  input wire logic signed [7:0] rate_wdata_i,
  input wire logic preset_wr_i,
  input wire logic signed [7:0] preset_wdata_i,
  input wire logic [2:0] sensor_type_i,
  input wire logic [15:0] loop_current_ua_i,
  input wire logic signed [7:0] out_rate_o,
  input wire logic rate_ack_o,
  input wire logic rate_nak_o,
  input wire logic preset_nak_o,
  input wire logic tenth_scale_o,
  input wire logic [2:0] linear_sel_o,
  input wire logic broken_sensor_o,
  input wire logic heat_off_o,
  input wire logic lo_alarm_contact_o,
  input wire logic [15:0] status_o,
  input wire logic drop_o,
  input wire logic tune_start_trial_o
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Change from automatic into manual
  sequence s_man_entry;
    $past(mode_i) == zone_pkg::MODE_AUTO && mode_i == zone_pkg::MODE_MANUAL;
  endsequence
  sequence s_rate_taken;
    rate_wr_i && mode_i == zone_pkg::MODE_MANUAL;
  endsequence
  AST_RATE_ACK: assert property (s_rate_taken |=>
    (rate_ack_o && !rate_nak_o) ##1 out_rate_o == $past(rate_wdata_i, 2))
    else $error("rate write lost");
  AST_RATE_NAK: assert property (
    rate_wr_i && mode_i != zone_pkg::MODE_MANUAL |=> rate_nak_o && !rate_ack_o)
    else $error("rate write not refused");
  AST_PRESET_NAK: assert property (preset_wr_i &&
    (preset_wdata_i > zone_pkg::RATE_FULL || preset_wdata_i < -zone_pkg::RATE_FULL)
    |=> preset_nak_o) else $error("preset not refused");
  AST_SOFT_KEEP: assert property (s_man_entry ##0 soft_change_i |->
    ##2 out_rate_o == $past(mean_rate_i, 2)) else $error("soft change lost");
  AST_LIN_SEL: assert property (
    $past(nrst_i) |=> linear_sel_o == $past(sensor_type_i))
    else $error("linearisation select wrong");
  AST_TENTH: assert property ($past(nrst_i) |=>
    tenth_scale_o == ($past(sensor_type_i) == zone_pkg::SENS_RTD_TENTH))
    else $error("tenth scaling wrong");
  AST_LOOP_BREAK: assert property (sensor_type_i == zone_pkg::SENS_LOOP &&
    loop_current_ua_i < zone_pkg::LOOP_BREAK_UA |=> broken_sensor_o)
    else $error("broken sensor missed");
  AST_SHORT_OUT: assert property (
    $rose(status_o[zone_pkg::STATUS_SHORT_BIT]) |-> ##1 (lo_alarm_contact_o && heat_off_o))
    else $error("short without contact");
  AST_SHORT_HOLD: assert property (status_o[zone_pkg::STATUS_SHORT_BIT] &&
    !reset_cmd_i && !power_up_i && !setpoint_wr_i && !$past(reset_cmd_i) &&
    !$past(power_up_i) && !$past(setpoint_wr_i) |=> status_o[zone_pkg::STATUS_SHORT_BIT])
    else $error("short dropped early");
  AST_SHORT_OFF: assert property (!short_sense_en_i &&
    !status_o[zone_pkg::STATUS_SHORT_BIT] |=> !status_o[zone_pkg::STATUS_SHORT_BIT])
    else $error("short while disabled");
  AST_DROP_TEL: assert property (global_standby_telegram_i |=> drop_o)
    else $error("telegram no drop");
  AST_TUNE_FULL: assert property (
    tune_start_trial_o && $past(tune_start_trial_o) |-> out_rate_o == zone_pkg::RATE_FULL)
    else $error("trial not at full");
endmodule // zone_supervision_and_tuning_chk

bind zone_supervision_and_tuning zone_supervision_and_tuning_chk i_chk (.*);

// ===== sim/zone_supervision_and_tuning_tb.sv
// Purpose: Self-checking bench of the zone supervision block
// Assumes: Four-cycle second tick, plant model on the sensor side
// Notes: Pulse answers are matched against a queue of notes
`timescale 1ns/1ps
module zone_supervision_and_tuning_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk_i = 1'b0, nrst_i = 1'b0, soft_change_i = 1'b0, short_sense_en_i = 1'b0;
  logic act_sense_en_i = 1'b0, standby_pin_i = 1'b0, global_standby_telegram_i = 1'b0;
  logic reset_cmd_i = 1'b0, power_up_i = 1'b0, rate_wr_i = 1'b0, preset_wr_i = 1'b0;
  logic setpoint_wr_i = 1'b0, cooling_active_i = 1'b0, tune_start_i = 1'b0, load = 1'b0;
  logic vmax_found_i = 1'b0;
  logic [1:0] mode_i = zone_pkg::MODE_OFF, fault = 2'h1;
  logic signed [7:0] mean_rate_i = 8'sh00, ctrl_rate_i = 8'sh00, min_rate_i = 8'sh00;
  logic signed [7:0] rate_wdata_i = 8'sh00, preset_wdata_i = 8'sh00, rnd;
  logic [2:0] sensor_type_i = 3'h0, linear_sel_o;
  logic [15:0] loop_current_ua_i = 16'h0000, status_o;
  logic signed [15:0] setpoint_i = 16'sh00C8, dev_limit_i = 16'sh000F, load_val = 16'sh0064;
  logic [9:0] diag_time_i = 10'h003;
  logic signed [15:0] raw_temp_i, host_temp_o;
  logic signed [7:0] out_rate_o;
  logic rate_ack_o, rate_nak_o, preset_nak_o, tenth_scale_o, broken_sensor_o, heat_off_o;
  logic lo_alarm_contact_o, hi_alarm_contact_o, deviation_alarm_o, drop_o;
  logic tune_start_trial_o, tune_osc_trial_o, tune_abort_o;
  logic [3:0] exp_q[$];
  int err_total = 0, checks = 0, seed = 35984;

  always #12.5 clk_i = ~clk_i;

  zone_supervision_and_tuning #(.TICK_CYCLES(4), .TIME_W(10)) i_zone_supervision_and_tuning (
    .clk_i, .nrst_i, .mode_i, .soft_change_i, .short_sense_en_i, .act_sense_en_i,
    .standby_pin_i, .global_standby_telegram_i, .reset_cmd_i, .power_up_i, .mean_rate_i,
    .ctrl_rate_i, .min_rate_i, .rate_wr_i, .rate_wdata_i, .preset_wr_i, .preset_wdata_i,
    .sensor_type_i, .loop_current_ua_i, .raw_temp_i, .setpoint_i, .setpoint_wr_i, .dev_limit_i,
    .diag_time_i, .cooling_active_i, .tune_start_i, .vmax_found_i, .out_rate_o, .rate_ack_o,
    .rate_nak_o, .preset_nak_o, .host_temp_o, .tenth_scale_o, .linear_sel_o, .broken_sensor_o,
    .heat_off_o, .lo_alarm_contact_o, .hi_alarm_contact_o, .status_o, .deviation_alarm_o,
    .drop_o, .tune_start_trial_o, .tune_osc_trial_o, .tune_abort_o);
  zone_plant i_zone_plant (.clk_i, .nrst_i, .load_i(load), .load_val_i(load_val),
    .heat_i(out_rate_o > 8'sh00 && !heat_off_o), .fault_i(fault), .temp_o(raw_temp_i));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Trailing idle cycle keeps a strobe from being set twice in one step
  task automatic pulse(ref logic sig);
    sig = 1'b1;
    step(1);
    sig = 1'b0;
    step(1);
  endtask
  task automatic set_temp(input logic signed [15:0] v);
    load_val = v;
    pulse(load);
  endtask
  // Bounded wait, then a compare of the final level
  task automatic wait_for(input string name, ref logic sig, input logic lvl);
    for (int n = 0; n < 300 && sig !== lvl; n++) begin
      step(1);
    end
    check(name, 16'(sig), 16'(lvl));
  endtask
  task automatic rate_write(input logic signed [7:0] d, input logic [3:0] ex);
    rate_wdata_i = d;
    exp_q.push_back(ex);
    pulse(rate_wr_i);
  endtask
  task final_report;
    if (exp_q.size() != 0) err_total++;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Pulse answers: ack, nak, preset nak, abort
  always @(posedge clk_i) begin
    if (nrst_i && (rate_ack_o | rate_nak_o | preset_nak_o | tune_abort_o)) begin
      if (exp_q.size() == 0) check("pulse", 16'h0001, 16'h0000);
      else check("pulse", {12'h000, rate_ack_o, rate_nak_o, preset_nak_o, tune_abort_o},
        {12'h000, exp_q.pop_front()});
    end
  end

  initial begin
    #200000;
    err_total++;
    final_report();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    step(5);
    nrst_i = 1'b1;
    step(2);
    for (int t = 0; t < 16; t++) begin
      sensor_type_i = t[2:0];
      loop_current_ua_i = 16'($random(seed) & 32'h0000_0FFF);
      step(2);
      check("linear_sel", 16'(linear_sel_o), 16'(t[2:0]));
      check("tenth", 16'(tenth_scale_o), 16'(t[2:0] == 3'h7));
      check("broken", 16'(broken_sensor_o), 16'(t[2:0] == 3'h6 &&
        loop_current_ua_i < zone_pkg::LOOP_BREAK_UA));
    end
    set_temp(16'sh09C4);
    step(2);
    check("host_temp", host_temp_o, zone_pkg::TENTH_RANGE_MAX);
    sensor_type_i = zone_pkg::SENS_RTD;
    mode_i = zone_pkg::MODE_AUTO;
    step(2);
    rate_write(8'sh10, 4'h4);
    mode_i = zone_pkg::MODE_MANUAL;
    step(2);
    check("preset_rst", out_rate_o, zone_pkg::PRESET_RST);
    preset_wdata_i = 8'sh65;
    exp_q.push_back(4'h2);
    pulse(preset_wr_i);
    preset_wdata_i = 8'sh9C;
    pulse(preset_wr_i);
    for (int i = 0; i < 4; i++) begin
      rnd = 8'($random(seed) % 101);
      rate_write(rnd, 4'h8);
      check("manual_rate", out_rate_o, rnd);
    end
    mode_i = zone_pkg::MODE_AUTO;
    step(2);
    mode_i = zone_pkg::MODE_MANUAL;
    step(2);
    check("thrust", out_rate_o, 8'sh9C);
    mode_i = zone_pkg::MODE_AUTO;
    soft_change_i = 1'b1;
    mean_rate_i = 8'($random(seed) % 101);
    step(2);
    mode_i = zone_pkg::MODE_MANUAL;
    step(3);
    check("soft", out_rate_o, mean_rate_i);
    mode_i = zone_pkg::MODE_AUTO;
    global_standby_telegram_i = 1'b1;
    step(2);
    check("drop_tel", 16'(drop_o), 16'h0001);
    global_standby_telegram_i = 1'b0;
    standby_pin_i = 1'b1;
    step(8);
    check("drop_pin", 16'(drop_o), 16'h0001);
    standby_pin_i = 1'b0;
    // Shorted sensor: full output, frozen reading far below setpoint
    ctrl_rate_i = zone_pkg::RATE_FULL;
    short_sense_en_i = 1'b1;
    set_temp(16'sh0064);
    wait_for("lo_contact", lo_alarm_contact_o, 1'b1);
    check("short_bit", status_o, 16'h0010);
    check("heat_off", 16'(heat_off_o), 16'h0001);
    check("deviation_alarm", 16'(deviation_alarm_o), 16'h0001);
    pulse(setpoint_wr_i);
    check("sel_clear", status_o, 16'h0000);
    wait_for("lo_again", lo_alarm_contact_o, 1'b1);
    pulse(power_up_i);
    check("pwr_clear", status_o, 16'h0000);
    short_sense_en_i = 1'b0;
    pulse(reset_cmd_i);
    step(60);
    check("sense_off", status_o, 16'h0000);
    // Stuck actuator: minimum output, temperature keeps climbing
    ctrl_rate_i = 8'sh00;
    act_sense_en_i = 1'b1;
    fault = 2'h2;
    set_temp(16'sh00E6);
    wait_for("hi_contact", hi_alarm_contact_o, 1'b1);
    fault = 2'h1;
    set_temp(16'sh00C8);
    wait_for("hi_clear", hi_alarm_contact_o, 1'b0);
    act_sense_en_i = 1'b0;
    fault = 2'h2;
    set_temp(16'sh00E6);
    step(60);
    check("act_off", 16'(hi_alarm_contact_o), 16'h0000);
    fault = 2'h1;
    set_temp(16'sh0064);
    pulse(tune_start_i);
    step(1);
    check("start_trial", 16'(tune_start_trial_o), 16'h0001);
    check("full", out_rate_o, zone_pkg::RATE_FULL);
    setpoint_i = 16'sh00C9;
    exp_q.push_back(4'h1);
    pulse(setpoint_wr_i);
    step(3);
    check("aborted", 16'(tune_start_trial_o), 16'h0000);
    set_temp(16'sh00BE);
    pulse(tune_start_i);
    check("osc_trial", 16'(tune_osc_trial_o), 16'h0001);
    pulse(vmax_found_i);
    step(3);
    cooling_active_i = 1'b1;
    exp_q.push_back(4'h1);
    pulse(tune_start_i);
    step(3);
    check("cool_osc", 16'(tune_osc_trial_o), 16'h0000);
    cooling_active_i = 1'b0;
    step(5);
    final_report();
  end
endmodule // zone_supervision_and_tuning_tb
